// ===== design/dtmc_consts.vh
`ifndef DTMC_CONSTS_VH
`define DTMC_CONSTS_VH
// Register indices; byte address is four times the index
`define DTMC_IDX_MODE      8'h89
`define DTMC_IDX_T0_LOW    8'h8a
`define DTMC_IDX_T1_LOW    8'h8b
`define DTMC_IDX_T0_HIGH   8'h8c
`define DTMC_IDX_T1_HIGH   8'h8d
`define DTMC_IDX_CONTROL   8'h88
`define DTMC_IDX_INTACK    8'h90
// Control register fields
`define DTMC_CTL_T1_FLAG   7
`define DTMC_CTL_T1_RUN    6
`define DTMC_CTL_T0_FLAG   5
`define DTMC_CTL_T0_RUN    4
// Mode register fields (per timer nibble)
`define DTMC_MODE_GATE     3
`define DTMC_MODE_SRC      2
`define DTMC_MODE_HI       1
`define DTMC_MODE_LO       0
`define DTMC_T1_NIB        4
// Mode encodings
`define DTMC_M13           2'h0
`define DTMC_M16           2'h1
`define DTMC_M8AR          2'h2
`define DTMC_MSPLIT        2'h3
// Reset values
`define DTMC_RST_BYTE      8'h00
// Timer tick: divided system clock
`define DTMC_TICK_DIV      12
`define DTMC_PRESC_MAX     5'h1f
`endif

// ===== design/dtmc_timer.v
`include "dtmc_consts.vh"
`default_nettype none
module dtmc_timer #(
	parameter TICK_DIV = `DTMC_TICK_DIV                // System clocks per timer tick
) (
	input  wire        i_clock,                    // System clock
	input  wire        i_reset_n,                  // Synchronous reset, active low
	input  wire        i_enable,                   // Clock enable, freezes all state
	input  wire [9:0]  i_address,                  // Avalon word address
	input  wire        i_read,                     // Avalon read
	input  wire        i_write,                    // Avalon write
	input  wire [31:0] i_writedata,                // Avalon write data
	input  wire [3:0]  i_byteenable,               // Avalon byte enables
	output reg  [31:0] o_readdata,                 // Avalon read data
	output wire        o_waitrequest,              // Avalon wait request
	input  wire        i_ext_irq0_pin,             // Gate pin for timer 0
	input  wire        i_ext_irq1_pin,             // Gate pin for timer 1
	input  wire        i_count_in_pin_0,           // Count pin for timer 0
	input  wire        i_count_in_pin_1,           // Count pin for timer 1
	input  wire        i_t0_vector_ack,            // Pulse: CPU vectors to timer 0 routine
	input  wire        i_t1_vector_ack,            // Pulse: CPU vectors to timer 1 routine
	output wire        o_t0_overflow_flag,         // Timer 0 overflow flag level
	output wire        o_t1_overflow_flag          // Timer 1 overflow flag level
);

	reg  [7:0]  timer_mode_select_q;
	reg  [7:0]  timer0_low_byte_q;
	reg  [7:0]  timer0_high_byte_q;
	reg  [7:0]  timer1_low_byte_q;
	reg  [7:0]  timer1_high_byte_q;
	reg         t0_run_q;
	reg         t1_run_q;
	reg         t0_overflow_flag_q;
	reg         t1_overflow_flag_q;
	reg  [15:0] div_q;
	wire        g0_s;
	wire        g1_s;
	wire        c0_s;
	wire        c1_s;
	reg         c0_prev_q;
	reg         c1_prev_q;
	reg         rd_wait_q;
	reg  [7:0]  rd_mux_d;

	// Pins are asynchronous; each passes two flops before any logic sees it
	dtmc_sync2 u_sync_g0 (
		.i_clock   (i_clock),
		.i_reset_n (i_reset_n),
		.i_enable  (i_enable),
		.i_pin     (i_ext_irq0_pin),
		.o_sync    (g0_s)
	);
	dtmc_sync2 u_sync_g1 (
		.i_clock   (i_clock),
		.i_reset_n (i_reset_n),
		.i_enable  (i_enable),
		.i_pin     (i_ext_irq1_pin),
		.o_sync    (g1_s)
	);
	dtmc_sync2 u_sync_c0 (
		.i_clock   (i_clock),
		.i_reset_n (i_reset_n),
		.i_enable  (i_enable),
		.i_pin     (i_count_in_pin_0),
		.o_sync    (c0_s)
	);
	dtmc_sync2 u_sync_c1 (
		.i_clock   (i_clock),
		.i_reset_n (i_reset_n),
		.i_enable  (i_enable),
		.i_pin     (i_count_in_pin_1),
		.o_sync    (c1_s)
	);

	wire [3:0]  t0_cfg = timer_mode_select_q[3:0];
	wire [3:0]  t1_cfg = timer_mode_select_q[7:4];
	wire [1:0]  t0_mode = t0_cfg[1:0];
	wire [1:0]  t1_mode = t1_cfg[1:0];
	wire        tick = (div_q == TICK_DIV - 1);
	// Edge detect reads only the second sync stage
	wire        c0_fall = c0_prev_q & ~c0_s;
	wire        c1_fall = c1_prev_q & ~c1_s;

	wire        t0_gate_ok = ~t0_cfg[`DTMC_MODE_GATE] | g0_s;
	wire        t1_gate_ok = ~t1_cfg[`DTMC_MODE_GATE] | g1_s;
	wire        t0_src = t0_cfg[`DTMC_MODE_SRC] ? c0_fall : tick;
	wire        t1_src = t1_cfg[`DTMC_MODE_SRC] ? c1_fall : tick;
	wire        t0_inc = i_enable & t0_run_q & t0_gate_ok & t0_src;
	// Split high byte always times the system clock, gated by timer 1 run only
	wire        t0h_inc = i_enable & t1_run_q & tick;
	wire        t1_inc = i_enable & t1_run_q & t1_gate_ok & t1_src &
	                     (t1_mode != `DTMC_MSPLIT);

	// Writes complete at once; a read stalls one cycle so that the
	// registered read data already stands at the accepting edge
	assign o_waitrequest = i_read & ~rd_wait_q;
	assign o_t0_overflow_flag = t0_overflow_flag_q;
	assign o_t1_overflow_flag = t1_overflow_flag_q;

	wire        bus_wr = i_write & i_byteenable[0];
	wire        wr_mode = bus_wr & (i_address == {2'h0, `DTMC_IDX_MODE});
	wire        wr_t0l = bus_wr & (i_address == {2'h0, `DTMC_IDX_T0_LOW});
	wire        wr_t1l = bus_wr & (i_address == {2'h0, `DTMC_IDX_T1_LOW});
	wire        wr_t0h = bus_wr & (i_address == {2'h0, `DTMC_IDX_T0_HIGH});
	wire        wr_t1h = bus_wr & (i_address == {2'h0, `DTMC_IDX_T1_HIGH});
	wire        wr_ctl = bus_wr & (i_address == {2'h0, `DTMC_IDX_CONTROL});

	// Next count values for each timer
	reg  [7:0]  t0l_d;
	reg  [7:0]  t0h_d;
	reg  [7:0]  t1l_d;
	reg  [7:0]  t1h_d;
	reg         t0_ovf;
	reg         t1_ovf;

	always @* begin
		t0l_d = timer0_low_byte_q;
		t0h_d = timer0_high_byte_q;
		t0_ovf = 1'b0;
		t1_ovf = 1'b0;
		if (t0_inc) begin
			case (t0_mode)
				`DTMC_M13: begin
					t0l_d = {timer0_low_byte_q[7:5], timer0_low_byte_q[4:0] + 5'h01};
					if (timer0_low_byte_q[4:0] == `DTMC_PRESC_MAX) begin
						t0h_d = timer0_high_byte_q + 8'h01;
						t0_ovf = (timer0_high_byte_q == 8'hff);
					end
				end
				`DTMC_M16: begin
					{t0h_d, t0l_d} = {timer0_high_byte_q, timer0_low_byte_q} + 16'h0001;
					t0_ovf = ({timer0_high_byte_q, timer0_low_byte_q} == 16'hffff);
				end
				`DTMC_M8AR: begin
					t0_ovf = (timer0_low_byte_q == 8'hff);
					t0l_d = t0_ovf ? timer0_high_byte_q : timer0_low_byte_q + 8'h01;
				end
				default: begin
					t0l_d = timer0_low_byte_q + 8'h01;
					t0_ovf = (timer0_low_byte_q == 8'hff);
				end
			endcase
		end
		if (t0_mode == `DTMC_MSPLIT && t0h_inc) begin
			t0h_d = timer0_high_byte_q + 8'h01;
			t1_ovf = (timer0_high_byte_q == 8'hff);
		end
	end

	always @* begin
		t1l_d = timer1_low_byte_q;
		t1h_d = timer1_high_byte_q;
		if (t1_inc) begin
			case (t1_mode)
				`DTMC_M13: begin
					t1l_d = {timer1_low_byte_q[7:5], timer1_low_byte_q[4:0] + 5'h01};
					if (timer1_low_byte_q[4:0] == `DTMC_PRESC_MAX)
						t1h_d = timer1_high_byte_q + 8'h01;
				end
				`DTMC_M16: begin
					{t1h_d, t1l_d} = {timer1_high_byte_q, timer1_low_byte_q} + 16'h0001;
				end
				`DTMC_M8AR: begin
					t1l_d = (timer1_low_byte_q == 8'hff) ? timer1_high_byte_q
					        : timer1_low_byte_q + 8'h01;
				end
				default: begin
					t1l_d = timer1_low_byte_q;
				end
			endcase
		end
	end

	// Read mux, sampled into the output flops on the stalled cycle
	always @* begin
		case (i_address)
			{2'h0, `DTMC_IDX_MODE}:    rd_mux_d = timer_mode_select_q;
			{2'h0, `DTMC_IDX_T0_LOW}:  rd_mux_d = timer0_low_byte_q;
			{2'h0, `DTMC_IDX_T1_LOW}:  rd_mux_d = timer1_low_byte_q;
			{2'h0, `DTMC_IDX_T0_HIGH}: rd_mux_d = timer0_high_byte_q;
			{2'h0, `DTMC_IDX_T1_HIGH}: rd_mux_d = timer1_high_byte_q;
			{2'h0, `DTMC_IDX_CONTROL}: rd_mux_d = {t1_overflow_flag_q, t1_run_q,
			                                       t0_overflow_flag_q, t0_run_q, 4'h0};
			default:                   rd_mux_d = 8'h00;
		endcase
	end

	// Timer 1 overflow, suppressed while timer 0 split owns the flag
	wire t1_own_ovf = t1_inc & (t0_mode != `DTMC_MSPLIT) & (
		(t1_mode == `DTMC_M13  && timer1_low_byte_q[4:0] == `DTMC_PRESC_MAX &&
		 timer1_high_byte_q == 8'hff) ||
		(t1_mode == `DTMC_M16  && {timer1_high_byte_q, timer1_low_byte_q} == 16'hffff) ||
		(t1_mode == `DTMC_M8AR && timer1_low_byte_q == 8'hff));

	always @(posedge i_clock) begin
		if (!i_reset_n) begin
			timer_mode_select_q <= `DTMC_RST_BYTE;
			timer0_low_byte_q <= `DTMC_RST_BYTE;
			timer0_high_byte_q <= `DTMC_RST_BYTE;
			timer1_low_byte_q <= `DTMC_RST_BYTE;
			timer1_high_byte_q <= `DTMC_RST_BYTE;
			t0_run_q <= 1'b0;
			t1_run_q <= 1'b0;
			t0_overflow_flag_q <= 1'b0;
			t1_overflow_flag_q <= 1'b0;
			div_q <= 16'h0000;
			c0_prev_q <= 1'b0;
			c1_prev_q <= 1'b0;
			rd_wait_q <= 1'b0;
			o_readdata <= 32'h00000000;
		end else if (i_enable) begin
			c0_prev_q <= c0_s;
			c1_prev_q <= c1_s;
			div_q <= tick ? 16'h0000 : div_q + 16'h0001;
			// Software write wins over counting in the same cycle
			timer0_low_byte_q <= wr_t0l ? i_writedata[7:0] : t0l_d;
			timer0_high_byte_q <= wr_t0h ? i_writedata[7:0] : t0h_d;
			timer1_low_byte_q <= wr_t1l ? i_writedata[7:0] : t1l_d;
			timer1_high_byte_q <= wr_t1h ? i_writedata[7:0] : t1h_d;
			if (wr_mode)
				timer_mode_select_q <= i_writedata[7:0];
			if (wr_ctl) begin
				t0_run_q <= i_writedata[`DTMC_CTL_T0_RUN];
				t1_run_q <= i_writedata[`DTMC_CTL_T1_RUN];
			end
			// Hardware set beats any clear in the same cycle
			if (t0_ovf)
				t0_overflow_flag_q <= 1'b1;
			else if (i_t0_vector_ack)
				t0_overflow_flag_q <= 1'b0;
			else if (wr_ctl)
				t0_overflow_flag_q <= i_writedata[`DTMC_CTL_T0_FLAG];
			if (t1_ovf | t1_own_ovf)
				t1_overflow_flag_q <= 1'b1;
			else if (i_t1_vector_ack)
				t1_overflow_flag_q <= 1'b0;
			else if (wr_ctl)
				t1_overflow_flag_q <= i_writedata[`DTMC_CTL_T1_FLAG];
			if (i_read && !rd_wait_q) begin
				o_readdata <= {24'h000000, rd_mux_d};
				rd_wait_q <= 1'b1;
			end else begin
				rd_wait_q <= 1'b0;
			end
		end
	end

endmodule // dtmc_timer

// Two-flop synchroniser for one asynchronous pin
module dtmc_sync2 (
	input  wire i_clock,   // System clock
	input  wire i_reset_n, // Synchronous reset, active low
	input  wire i_enable,  // Clock enable, freezes the stages
	input  wire i_pin,     // Asynchronous pin level
	output wire o_sync     // Pin level after two flops
);

	reg  [1:0]  stage_q;

	always @(posedge i_clock) begin
		if (!i_reset_n) begin
			stage_q <= 2'h0;
		end else if (i_enable) begin
			stage_q <= {stage_q[0], i_pin};
		end
	end

	assign o_sync = stage_q[1];

endmodule // dtmc_sync2
`default_nettype wire

// ===== test/dtmc_pins_model.sv
`default_nettype none
module dtmc_pins_model (
	input  wire logic       i_clock, // System clock
	output var  logic [1:0] o_gate,  // Gate pins, bit 1 for timer 1
	output var  logic [1:0] o_count  // Count pins, idle high
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		o_gate = 2'h0;
		o_count = 2'h3;
	end
	// Three clocks per level so the two-stage sync never drops an edge
	task automatic pulse(input int ch, input int n);
		repeat (n) begin
			repeat (3) @(posedge i_clock);
			o_count[ch] <= 1'b0;
			repeat (3) @(posedge i_clock);
			o_count[ch] <= 1'b1;
		end
		repeat (4) @(posedge i_clock);
	endtask
	task automatic gate(input int ch, input logic v);
		@(posedge i_clock);
		o_gate[ch] <= v;
	endtask
endmodule // dtmc_pins_model
`default_nettype wire

// ===== test/dtmc_timer_monitor.sv
`default_nettype none
module dtmc_timer_monitor (
	input wire logic        i_clock, i_reset_n, i_enable, i_read, i_write,
	input wire logic [9:0]  i_address,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0]  i_byteenable,
	input wire logic        i_t0_vector_ack, i_t1_vector_ack,
	input wire logic [31:0] o_readdata,
	input wire logic        o_waitrequest, o_t0_overflow_flag, o_t1_overflow_flag
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);
	wire logic wr0 = i_write && i_enable && i_byteenable[0];
	AST_RESET_CLEAR: assert property (disable iff (1'b0) !i_reset_n |=>
		!o_t0_overflow_flag && !o_t1_overflow_flag && o_readdata == 32'h0)
		else $error("outputs not clear after reset");
	AST_NO_WAIT: assert property (i_write && !i_read |-> !o_waitrequest)
		else $error("waitrequest raised on write");
	AST_RD_ONE_WAIT: assert property (i_read && i_enable && o_waitrequest
		|=> !(i_read && i_enable && o_waitrequest)) else $error("read stalled too long");
	AST_MODE_READBACK: assert property (wr0 && i_address == 10'h089 ##1 !i_write ##1
		i_read && i_enable && i_address == 10'h089 && o_waitrequest |=>
		o_readdata[7:0] == $past(i_writedata[7:0], 3)) else $error("mode readback wrong");
	AST_UNMAPPED_ZERO: assert property (i_read && i_enable && i_address == 10'h08e
		|=> o_readdata == 32'h0) else $error("unmapped read not zero");
	AST_FROZEN: assert property (!i_enable |=> $stable(o_readdata) &&
		$stable(o_t0_overflow_flag) && $stable(o_t1_overflow_flag))
		else $error("state moved while disabled");
	AST_F0_HOLD: assert property (o_t0_overflow_flag && !i_t0_vector_ack && !i_write
		|=> o_t0_overflow_flag) else $error("timer 0 flag lost");
	AST_F1_HOLD: assert property (o_t1_overflow_flag && !i_t1_vector_ack && !i_write
		|=> o_t1_overflow_flag) else $error("timer 1 flag lost");
	AST_F0_SET_BY_WRITE: assert property (wr0 && i_address == 10'h088 && i_writedata[5] &&
		!i_t0_vector_ack
		|=> o_t0_overflow_flag) else $error("timer 0 flag write ignored");
	AST_RD_HOLD: assert property (!i_read |=> $stable(o_readdata))
		else $error("read data changed without read");
	cover property (wr0 && i_address == 10'h089);
	cover property ($rose(o_t0_overflow_flag));
	cover property ($rose(o_t1_overflow_flag));
	cover property (i_read && o_waitrequest ##1 i_read && !o_waitrequest);
endmodule // dtmc_timer_monitor
bind dtmc_timer dtmc_timer_monitor u_mon (.*);
`default_nettype wire

// ===== test/testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0, rst_n = 1'b0, en = 1'b1, rd_s = 1'b0, wr_s = 1'b0;
	logic        ack0 = 1'b0, ack1 = 1'b0, wait_s, f0, f1;
	logic [9:0]  adr = 10'h000;
	logic [31:0] wdat = 32'h0, rdat;
	logic [3:0]  be = 4'hf;
	logic [1:0]  gate, cnt;
	logic [7:0]  rd;
	logic [7:0]  regs [7] = '{8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h88, 8'h8e};
	int          bad_count = 0, cmp_count = 0;
	always #5 clk = ~clk;
	dtmc_pins_model pins (.i_clock(clk), .o_gate(gate), .o_count(cnt));
	dtmc_timer #(.TICK_DIV(2)) uut (.i_clock(clk), .i_reset_n(rst_n), .i_enable(en),
		.i_address(adr), .i_read(rd_s), .i_write(wr_s), .i_writedata(wdat),
		.i_byteenable(be), .o_readdata(rdat), .o_waitrequest(wait_s),
		.i_ext_irq0_pin(gate[0]), .i_ext_irq1_pin(gate[1]), .i_count_in_pin_0(cnt[0]),
		.i_count_in_pin_1(cnt[1]), .i_t0_vector_ack(ack0), .i_t1_vector_ack(ack1),
		.o_t0_overflow_flag(f0), .o_t1_overflow_flag(f1));
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		adr <= {2'h0, a};
		wdat <= {24'h0, d};
		wr_s <= 1'b1;
		do @(posedge clk); while (wait_s !== 1'b0);
		wr_s <= 1'b0;
		// Idle edge so back-to-back calls never drive a strobe twice at once
		@(posedge clk);
	endtask
	// Read data stands at the edge where waitrequest is sampled low
	task automatic rd_get(input logic [7:0] a);
		adr <= {2'h0, a};
		rd_s <= 1'b1;
		do @(posedge clk); while (wait_s !== 1'b0);
		rd = rdat[7:0];
		rd_s <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		rd_get(a);
		check(rd, e);
	endtask
	task automatic ack(input logic t);
		ack0 <= !t;
		ack1 <= t;
		@(posedge clk);
		ack0 <= 1'b0;
		ack1 <= 1'b0;
		@(posedge clk);
	endtask
	task automatic test_done();
		$display("counts: %0d compares, %0d mismatches", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		bad_count++;
		test_done();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		foreach (regs[i]) rd_chk(regs[i], 8'h00);
		en <= 1'b0;
		repeat (3) @(posedge clk);
		en <= 1'b1;
		wr(8'h89, 8'h5a);
		rd_chk(8'h89, 8'h5a);
		be <= 4'he;
		wr(8'h89, 8'h33);
		be <= 4'hf;
		rd_chk(8'h89, 8'h5a);
		$display("done registers");
		wr(8'h89, 8'h55);
		wr(8'h88, 8'h50);
		pins.pulse(0, 5);
		pins.pulse(1, 3);
		wr(8'h88, 8'h00);
		pins.pulse(0, 2);
		rd_chk(8'h8a, 8'h05);
		rd_chk(8'h8b, 8'h03);
		$display("done counters");
		wr(8'h8a, 8'h00);
		wr(8'h8b, 8'h00);
		wr(8'h89, 8'h99);
		wr(8'h88, 8'h50);
		repeat (20) @(posedge clk);
		rd_chk(8'h8b, 8'h00);
		rd_chk(8'h8a, 8'h00);
		pins.gate(1, 1'b1);
		repeat (20) @(posedge clk);
		rd_get(8'h8b);
		check(8'(rd > 8'd4), 8'h01);
		pins.gate(1, 1'b0);
		wr(8'h88, 8'h00);
		wr(8'h8b, 8'h00);
		wr(8'h89, 8'h11);
		wr(8'h88, 8'h40);
		repeat (20) @(posedge clk);
		wr(8'h88, 8'h00);
		rd_get(8'h8b);
		check(8'(rd inside {[8'd9:8'd12]}), 8'h01);
		$display("done gating");
		wr(8'h89, 8'h66);
		wr(8'h8c, 8'hf0);
		wr(8'h8a, 8'hfe);
		wr(8'h8d, 8'h80);
		wr(8'h8b, 8'hff);
		wr(8'h88, 8'h50);
		pins.pulse(0, 5);
		pins.pulse(1, 2);
		rd_chk(8'h8a, 8'hf3);
		rd_chk(8'h8c, 8'hf0);
		rd_chk(8'h8b, 8'h81);
		check({6'h0, f1, f0}, 8'h03);
		ack(1'b0);
		check({6'h0, f1, f0}, 8'h02);
		ack(1'b1);
		check({6'h0, f1, f0}, 8'h00);
		wr(8'h88, 8'ha0);
		rd_chk(8'h88, 8'ha0);
		$display("done reload");
		wr(8'h89, 8'h04);
		wr(8'h8c, 8'h00);
		wr(8'h8a, 8'h1e);
		wr(8'h88, 8'h10);
		pins.pulse(0, 3);
		rd_get(8'h8a);
		check({3'h0, rd[4:0]}, 8'h01);
		rd_chk(8'h8c, 8'h01);
		$display("done prescaler");
		wr(8'h88, 8'h00);
		wr(8'h8b, 8'h42);
		wr(8'h8a, 8'h00);
		wr(8'h8c, 8'hfe);
		wr(8'h89, 8'h37);
		wr(8'h88, 8'h50);
		pins.pulse(0, 2);
		pins.pulse(1, 2);
		rd_chk(8'h8a, 8'h02);
		rd_chk(8'h8b, 8'h42);
		check({7'h0, f1}, 8'h01);
		$display("done split");
		test_done();
	end
endmodule // testbench
`default_nettype wire
